// ### ddr_burst4_sram_interface.sv
// Burst-of-four DDR static memory device logic and its read data FIFO
`timescale 1ns/1ps
`include "ddr_params.svh"

////////////////////////////////////////////////////////////////////////////////
module burst_fifo #(
    parameter int W = `DATA_W,
    parameter int D = `FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    // Fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0]   FULL = (AW+1)'(D);
    localparam logic [AW-1:0] LAST = AW'(D-1);

    logic [W-1:0]  store [D];
    logic [AW-1:0] wr_idx, next_wr_idx, rd_idx, next_rd_idx;
    logic [AW:0]   count, next_count;
    logic          push, pop;

    // Honest flags straight from the fill count
    assign in_ready_o  = count != FULL;
    assign out_valid_o = count != '0;
    assign out_data_o  = store[rd_idx];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Pointer and count update
    always_comb begin
        next_wr_idx = wr_idx;
        next_rd_idx = rd_idx;
        next_count  = count;
        if (push) begin
            next_wr_idx = (wr_idx == LAST) ? '0 : wr_idx + 1'b1;
        end
        if (pop) begin
            next_rd_idx = (rd_idx == LAST) ? '0 : rd_idx + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count  <= '0;
        end else begin
            wr_idx <= next_wr_idx;
            rd_idx <= next_rd_idx;
            count  <= next_count;
        end
    end

    // Storage has no reset; only written entries are ever read
    always_ff @(posedge clk_i) begin
        if (push) begin
            store[wr_idx] <= in_data_i;
        end
    end
endmodule : burst_fifo

////////////////////////////////////////////////////////////////////////////////
module ddr_burst4_sram_interface import sram_pkg::*; #(
    parameter bit X36    = 1'b1,
    parameter int MEM_AW = `MEM_AW_DEF
) (
    // System clock and reset
    input  wire logic                   MCLK_I,
    input  wire logic                   RST_B_I,
    // Input clock pair, output clock pair and loop disable
    input  wire logic                   K_I,
    input  wire logic                   K_N_I,
    input  wire logic                   C_I,
    input  wire logic                   C_N_I,
    input  wire logic                   DLL_OFF_N_I,
    // Command and write port
    input  wire logic [`ADDR_W_MAX-1:0] WORD_ADDR_I,
    input  wire logic                   RD_N_I,
    input  wire logic                   WR_N_I,
    input  wire logic [`DATA_W-1:0]     D_I,
    input  wire logic [`LANES_WIDE-1:0] LANE_MASK_N_I,
    // Read port and echo clocks
    output logic [`DATA_W-1:0]          Q_O,
    output logic                        ECHO_CLK_O,
    output logic                        ECHO_CLK_N_O
);
    localparam int LANES = X36 ? `LANES_WIDE : `LANES_NARROW;
    localparam int AW    = X36 ? `ADDR_W_WIDE : `ADDR_W_NARROW;
    localparam int IW    = MEM_AW + 2;

    // Lane-masked merge of one beat into a stored word
    function automatic logic [`DATA_W-1:0] merge(input logic [`DATA_W-1:0] old_w,
                                                 input logic [`DATA_W-1:0] new_w,
                                                 input logic [`LANES_WIDE-1:0] m_n);
        logic [`DATA_W-1:0] r;
        r = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (!m_n[i]) begin
                r[i*`LANE_W +: `LANE_W] = new_w[i*`LANE_W +: `LANE_W];
            end
        end
        return r;
    endfunction : merge

    // Memory word index: burst group plus beat
    function automatic logic [IW-1:0] widx(input logic [`ADDR_W_MAX-1:0] a, input logic [1:0] b);
        return {a[MEM_AW-1:0], b};
    endfunction : widx

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers, third stage only for edge finding
    pins_t      p1, p2;
    logic [4:0] lk1, lk2, lk3;
    logic       k_r, kn_r, use_k, ec, ecn, ec_d, ecn_d, ec_r, ecn_r;

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            p1     <= '0;
            p2     <= '0;
            // Idle pin levels, so no false edge follows reset
            lk1    <= 5'h1A;
            lk2    <= 5'h1A;
            lk3    <= 5'h1A;
            ec_d   <= 1'b0;
            ecn_d  <= 1'b1;
        end else begin
            p1     <= '{RD_N_I, WR_N_I, WORD_ADDR_I, D_I, LANE_MASK_N_I};
            p2     <= p1;
            lk1    <= {DLL_OFF_N_I, C_N_I, C_I, K_N_I, K_I};
            lk2    <= lk1;
            lk3    <= lk2;
            ec_d   <= ec;
            ecn_d  <= ecn;
        end
    end

    assign k_r   = lk2[0] && !lk3[0];
    assign kn_r  = lk2[1] && !lk3[1];
    assign use_k = lk2[2] && lk2[3];
    assign ec    = use_k ? lk2[0] : lk2[2];
    assign ecn   = use_k ? lk2[1] : lk2[3];
    assign ec_r  = ec && !ec_d;
    assign ecn_r = ecn && !ecn_d;

    ////////////////////////////////////////////////////////////////////////////
    // Write port: command on K, beats alternate K and K complement
    logic [`DATA_W-1:0]     mem [2**IW];
    wstate_t                wst, next_wst;
    logic [`ADDR_W_MAX-1:0] waddr, next_waddr, wpaddr, next_wpaddr;
    logic                   wpend, next_wpend, we;
    logic [1:0]             wbeat;
    logic [`DATA_W-1:0]     next_word;

    always_comb begin
        next_wst    = wst;
        next_waddr  = waddr;
        next_wpend  = wpend;
        next_wpaddr = wpaddr;
        we          = 1'b0;
        wbeat       = 2'd0;
        case (wst)
            W_IDLE: begin
                if (k_r && !p2.wr_n) begin
                    next_wst   = W_B1;
                    next_waddr = p2.word_addr & `ADDR_W_MAX'((1 << AW) - 1);
                end
            end
            W_B1: if (k_r) begin
                we       = 1'b1;
                next_wst = W_B2;
            end
            W_B2: if (kn_r) begin
                we       = 1'b1;
                wbeat    = 2'd1;
                next_wst = W_B3;
            end
            W_B3: begin
                if (k_r) begin
                    we       = 1'b1;
                    wbeat    = 2'd2;
                    next_wst = W_B4;
                end
                // Next command may land on beat three's edge
                if (k_r && !p2.wr_n) begin
                    next_wpend  = 1'b1;
                    next_wpaddr = p2.word_addr & `ADDR_W_MAX'((1 << AW) - 1);
                end
            end
            W_B4: if (kn_r) begin
                we         = 1'b1;
                wbeat      = 2'd3;
                next_wst   = wpend ? W_B1 : W_IDLE;
                next_waddr = wpend ? wpaddr : waddr;
                next_wpend = 1'b0;
            end
            default: next_wst = W_IDLE;
        endcase
        next_word = merge(mem[widx(waddr, wbeat)], p2.data, p2.lane_mask_n);
    end

    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            wst    <= W_IDLE;
            waddr  <= '0;
            wpend  <= 1'b0;
            wpaddr <= '0;
        end else begin
            wst    <= next_wst;
            waddr  <= next_waddr;
            wpend  <= next_wpend;
            wpaddr <= next_wpaddr;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (we) begin
            mem[widx(waddr, wbeat)] <= next_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port: fetch four words into the FIFO, launch on output clocks, or on K clocks when both output clocks are high
    logic [`ADDR_W_MAX-1:0] raddr, next_raddr;
    logic [2:0]             fetch, next_fetch;
    logic [1:0]             wait_cnt, next_wait, left, next_left;
    logic                   exp_t, next_exp_t, emit;
    logic                   f_in_ready, f_out_valid;
    logic [`DATA_W-1:0]     f_out_data, qa, next_qa;
    logic [1:0]             echo_a, next_echo_a;
    logic                   dll_on;

    assign dll_on = lk2[4];

    always_comb begin
        next_raddr = raddr;
        next_fetch = fetch;
        next_wait  = wait_cnt;
        next_left  = left;
        next_exp_t = exp_t;
        emit       = 1'b0;
        if (fetch != 3'd0 && f_in_ready) begin // Stalls while FIFO full
            next_fetch = fetch - 3'd1;
        end
        if (wait_cnt != 2'd0 && ecn_r) begin
            next_wait = wait_cnt - 2'd1;
            if (wait_cnt == 2'd1) begin
                emit       = 1'b1;
                next_left  = 2'd3;
                next_exp_t = 1'b1;
            end
        end
        if (left != 2'd0 && (exp_t ? ec_r : ecn_r)) begin
            emit       = 1'b1;
            next_left  = left - 2'd1;
            next_exp_t = !exp_t;
        end
        if (k_r && !p2.rd_n) begin
            next_raddr = p2.word_addr & `ADDR_W_MAX'((1 << AW) - 1);
            next_fetch = 3'(`BURST_LEN);
            next_wait  = 2'(`LAUNCH_EDGES);
        end
        next_qa     = (emit && f_out_valid) ? f_out_data : qa;
        next_echo_a = {ecn, ec};
    end

    // Loop disabled: outputs lag one extra stage, no alignment
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            raddr        <= '0;
            fetch        <= '0;
            wait_cnt     <= '0;
            left         <= '0;
            exp_t        <= 1'b0;
            qa           <= '0;
            echo_a       <= '0;
            Q_O          <= '0;
            ECHO_CLK_O   <= 1'b0;
            ECHO_CLK_N_O <= 1'b0;
        end else begin
            raddr        <= next_raddr;
            fetch        <= next_fetch;
            wait_cnt     <= next_wait;
            left         <= next_left;
            exp_t        <= next_exp_t;
            qa           <= next_qa;
            echo_a       <= next_echo_a;
            Q_O          <= dll_on ? next_qa : qa;
            ECHO_CLK_O   <= dll_on ? next_echo_a[0] : echo_a[0];
            ECHO_CLK_N_O <= dll_on ? next_echo_a[1] : echo_a[1];
        end
    end

    burst_fifo #(.W(`DATA_W), .D(`FIFO_DEPTH)) rd_fifo (
        .clk_i      (MCLK_I),
        .rst_b_i    (RST_B_I),
        .in_valid_i (fetch != 3'd0),
        .in_ready_o (f_in_ready),
        .in_data_i  (mem[widx(raddr, 2'(3'(`BURST_LEN) - fetch))]),
        .out_valid_o(f_out_valid),
        .out_ready_i(emit),
        .out_data_o (f_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_B_I);

    sequence rd_cmd_s;
        k_r && !p2.rd_n;
    endsequence
    sequence fetch_done_s;
        ##[4:60] fetch == 3'd0;
    endsequence

    burst_four_a: assert property (rd_cmd_s |=> fetch == 3'd4)
        else $error("read did not load four beats");
    fetch_end_a: assert property (rd_cmd_s |-> fetch_done_s)
        else $error("read fetch did not finish");
    wr_ignore_a: assert property (k_r && p2.wr_n && wst == W_IDLE |=> wst == W_IDLE)
        else $error("write started without request");
    rd_ignore_a: assert property (k_r && p2.rd_n && fetch == 3'd0 |=> fetch == 3'd0)
        else $error("read started without request");
    beat_edge_a: assert property (we |-> (k_r && (wst == W_B1 || wst == W_B3))
                                      || (kn_r && (wst == W_B2 || wst == W_B4)))
        else $error("write beat on wrong clock edge");
    wr_follow_a: assert property (wst == W_IDLE && k_r && !p2.wr_n |=> !we until k_r)
        else $error("first write beat too early");
    launch_edge_a: assert property (wait_cnt == 2'd1 && ecn_r |=> left == 2'd3)
        else $error("read burst not launched");
    burst_step_a: assert property (left != 2'd0 && exp_t && ec_r |=> left == $past(left) - 2'd1 && !exp_t)
        else $error("true clock beat not taken");
    kclk_mode_a: assert property (use_k && dll_on |=>
        ECHO_CLK_O == $past(lk2[0]) && ECHO_CLK_N_O == $past(lk2[1]))
        else $error("clock select wrong");
    echo_align_a: assert property (dll_on && $rose(ec) |=> ECHO_CLK_O)
        else $error("echo clock not aligned");
    masked_keep_a: assert property (we && (&p2.lane_mask_n[LANES-1:0]) |-> next_word == mem[widx(waddr, wbeat)])
        else $error("masked lanes written");
endmodule : ddr_burst4_sram_interface

// ### ddr_params.svh
// Constants for the burst-of-four DDR static memory interface
// Contract
// - Every access moves exactly four words
// - Separate read and write data ports
// - Shared address bus, captured per K edge
// - K rise captures address, commands, beats 1,3
// - K complement rise captures beats 2,4
// - Byte masks sampled per beat
// - Write takes two cycles, spacing two
// - Read beats 1,3 on C complement edges
// - Read beats 2,4 on C edges
// - Both output clocks high selects K timing
// - Read takes two cycles, spacing two
// - Echo clocks aligned with read data
// - Write request active low
// - Read request active low
// - Lane masks active low, high blocks write
// - Loop disable low switches off alignment
`ifndef DDR_PARAMS_SVH
`define DDR_PARAMS_SVH
`define ADDR_W_WIDE   20
`define ADDR_W_NARROW 21
`define ADDR_W_MAX    21
`define DATA_W        36
`define LANE_W        9
`define LANES_WIDE    4
`define LANES_NARROW  2
`define BURST_LEN     4
`define FIFO_DEPTH    8
`define LAUNCH_EDGES  2
`define MEM_AW_DEF    6
`endif

// ### sram_pkg.sv
// Types for the burst-of-four DDR static memory interface
`include "ddr_params.svh"
package sram_pkg;
    // Pins sampled together with the link clocks
    typedef struct packed {
        logic                     rd_n;
        logic                     wr_n;
        logic [`ADDR_W_MAX-1:0]   word_addr;
        logic [`DATA_W-1:0]       data;
        logic [`LANES_WIDE-1:0]   lane_mask_n;
    } pins_t;

    // Write burst progress
    typedef enum logic [2:0] {
        W_IDLE = 3'b000,
        W_B1   = 3'b001,
        W_B2   = 3'b010,
        W_B3   = 3'b011,
        W_B4   = 3'b100
    } wstate_t;
endpackage : sram_pkg

// ### ctl_model.sv
// Behavioural memory controller that drives the link pins
`timescale 1ns/1ps
`include "ddr_params.svh"

////////////////////////////////////////////////////////////////////////////////
module ctl_model (
    // Output clock mode
    input  wire logic              c_tied_i,
    // Link clocks
    output logic                   k_o,
    output logic                   k_n_o,
    output logic                   c_o,
    output logic                   c_n_o,
    // Command and write beats
    output logic [`ADDR_W_MAX-1:0] addr_o,
    output logic                   rd_n_o,
    output logic                   wr_n_o,
    output logic [`DATA_W-1:0]     d_o,
    output logic [`LANES_WIDE-1:0] m_o
);
    // Output pair trails the input pair by a quarter period, so K and C timing differ
    assign #20 c_o   = c_tied_i | k_o;
    assign #20 c_n_o = c_tied_i | k_n_o;

    // Clocks stand still between cycles
    initial begin
        k_o    = 1'b0;
        k_n_o  = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        addr_o = '0;
        d_o    = '0;
        m_o    = '1;
    end

    // One K period; pins change midway between edges for margin on both sides
    task automatic cycle(input logic rd_n, input logic wr_n, input logic [`ADDR_W_MAX-1:0] a,
                         input logic [`DATA_W-1:0] dr, input logic [`DATA_W-1:0] df,
                         input logic [`LANES_WIDE-1:0] mr, input logic [`LANES_WIDE-1:0] mf);
        rd_n_o = rd_n;
        wr_n_o = wr_n;
        addr_o = a;
        d_o    = dr;
        m_o    = mr;
        #20 k_o = 1'b1;
        k_n_o  = 1'b0;
        #20 rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        addr_o = ~a;
        d_o    = df;
        m_o    = mf;
        #20 k_o = 1'b0;
        k_n_o  = 1'b1;
        #20;
    endtask : cycle
endmodule : ctl_model

// ### ddr_burst4_sram_interface_test.sv
// Self-checking bench for the burst-of-four DDR memory interface
`timescale 1ns/1ps
`include "ddr_params.svh"

////////////////////////////////////////////////////////////////////////////////
module ddr_burst4_sram_interface_test import sram_pkg::*;;
    logic                   mclk, rst_b, k, k_n, c, c_n, dll_off_n, c_tied, rd_n, wr_n, e, e_n;
    logic [`ADDR_W_MAX-1:0] a;
    logic [`DATA_W-1:0]     d, q, ql;
    logic [`LANES_WIDE-1:0] m;
    logic                   c_rd [16];
    logic                   c_wr [16];
    logic [`ADDR_W_MAX-1:0] c_a  [16];
    logic [`DATA_W-1:0]     c_dr [16];
    logic [`DATA_W-1:0]     c_df [16];
    logic [`LANES_WIDE-1:0] c_mr [16];
    logic [`LANES_WIDE-1:0] c_mf [16];
    logic [`DATA_W-1:0]     em   [256];
    logic [`DATA_W-1:0]     ev[$], qv[$];
    logic [1:0]             qe[$];
    realtime                qt[$], t0;
    int                     fails, compares;

    ctl_model i_ctl (.c_tied_i(c_tied), .k_o(k), .k_n_o(k_n), .c_o(c), .c_n_o(c_n), .addr_o(a),
                     .rd_n_o(rd_n), .wr_n_o(wr_n), .d_o(d), .m_o(m));
    ddr_burst4_sram_interface i_dut (.MCLK_I(mclk), .RST_B_I(rst_b), .K_I(k), .K_N_I(k_n), .C_I(c),
        .C_N_I(c_n), .DLL_OFF_N_I(dll_off_n), .WORD_ADDR_I(a), .RD_N_I(rd_n), .WR_N_I(wr_n),
        .D_I(d), .LANE_MASK_N_I(m), .Q_O(q), .ECHO_CLK_O(e), .ECHO_CLK_N_O(e_n));

    // System clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Log every read beat as it lands, with the echo pair beside it
    always @(posedge mclk) begin
        #1;
        if (q !== ql) begin
            qv.push_back(q);
            qe.push_back({e, e_n});
            qt.push_back($realtime);
            ql = q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [`DATA_W-1:0] word(input int s, input int b);
        return {8'(s), 4'(b), 24'h00_A5C3};
    endfunction : word

    task automatic check(input string n, input logic [`DATA_W-1:0] x, input logic [`DATA_W-1:0] s);
        compares++;
        if (s !== x) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, s);
        end
    endtask : check

    task automatic give_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    // Idle cycles carry a data pattern that flips every cycle, never the last beat
    task automatic clr();
        for (int i = 0; i < 16; i++) begin
            c_rd[i] = 1'b1;
            c_wr[i] = 1'b1;
            c_a[i]  = 21'(i * 3);
            c_dr[i] = i[0] ? 36'h5_5555_5555 : 36'hA_AAAA_AAAA;
            c_df[i] = ~c_dr[i];
            c_mr[i] = 4'hF;
            c_mf[i] = 4'h0;
        end
        ev.delete();
        qv.delete();
        qe.delete();
        qt.delete();
    endtask : clr

    // Beats 1,3 on the two K rises after the command, 2,4 on the K_N rises
    task automatic put_wr(input int cy, input logic [20:0] ad, input int s, input logic [15:0] mk, input bit go);
        logic [`DATA_W-1:0] w;
        c_wr[cy] = !go;
        c_a[cy]  = ad;
        for (int b = 0; b < 4; b++) begin
            w = word(s, b);
            if (b % 2 == 0) begin
                c_dr[cy + 1 + b / 2] = w;
                c_mr[cy + 1 + b / 2] = mk[b*4+:4];
            end else begin
                c_df[cy + 1 + b / 2] = w;
                c_mf[cy + 1 + b / 2] = mk[b*4+:4];
            end
            for (int l = 0; l < 4; l++)
                if (go && !mk[b*4+l]) em[ad[5:0]*4+b][l*9+:9] = w[l*9+:9];
        end
    endtask : put_wr

    task automatic put_rd(input int cy, input logic [20:0] ad, input bit go);
        c_rd[cy] = !go;
        c_a[cy]  = ad;
        for (int b = 0; b < 4; b++)
            if (go) ev.push_back(em[ad[5:0]*4+b]);
    endtask : put_rd

    task automatic run(input int n);
        @(posedge mclk);
        #3;
        t0 = $realtime;
        for (int i = 0; i < n; i++)
            i_ctl.cycle(c_rd[i], c_wr[i], c_a[i], c_dr[i], c_df[i], c_mr[i], c_mf[i]);
        repeat (10) @(posedge mclk);
        #3;
    endtask : run

    // Beats arrive in order, C_N-timed beats with the echo low and the others with it high
    task automatic judge(input string name);
        check("beats", 36'(ev.size()), 36'(qv.size()));
        for (int i = 0; i < ev.size() && i < qv.size(); i++) begin
            check("q", ev[i], qv[i]);
            check("echo", 36'(i % 2 ? 2'b10 : 2'b01), 36'(qe[i]));
        end
        $display("%s done", name);
    endtask : judge

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_basic();
        clr();
        put_wr(0, 21'h0_0005, 1, 16'h0000, 1);
        put_rd(4, 21'h0_0005, 1);
        run(9);
        // 1.5 cycles plus the C lag, then two to four clocks of sampling
        check("latency", 1, 36'(qt[0] - t0 - 340.0 > 160.0 && qt[0] - t0 - 340.0 < 182.0));
        judge("basic");
    endtask : t_basic

    task automatic t_mask();
        clr();
        put_wr(0, 21'h0_0012, 2, 16'h0000, 1);
        put_wr(2, 21'h0_0012, 3, 16'h0F5A, 1);
        put_rd(5, 21'h0_0012, 1);
        run(10);
        judge("mask");
    endtask : t_mask

    task automatic t_conc();
        clr();
        put_rd(0, 21'h0_0005, 1);
        put_wr(1, 21'h0_003F, 4, 16'h0000, 1);
        put_rd(2, 21'h0_0012, 1);
        put_rd(5, 21'h0_003F, 1);
        run(10);
        judge("concurrent");
    endtask : t_conc

    task automatic t_refuse();
        clr();
        put_wr(0, 21'h0_0005, 5, 16'h0000, 0);
        put_rd(3, 21'h0_0012, 0);
        put_rd(6, 21'h0_0005, 1);
        run(11);
        judge("refuse");
    endtask : t_refuse

    task automatic t_modes();
        clr();
        c_tied = 1'b1;
        put_rd(0, 21'h0_003F, 1);
        run(5);
        check("k timed", 1, 36'(qt[0] - t0 - 20.0 > 140.0 && qt[0] - t0 - 20.0 < 162.0));
        c_tied = 1'b0;
        dll_off_n = 1'b0;
        put_rd(0, 21'h0_0012, 1);
        run(5);
        check("dll lag", 1, 36'(qt[4] - t0 - 20.0 > 170.0 && qt[4] - t0 - 20.0 < 192.0));
        dll_off_n = 1'b1;
        judge("modes");
    endtask : t_modes

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        fails = 0;
        compares = 0;
        rst_b = 1'b0;
        dll_off_n = 1'b1;
        c_tied = 1'b0;
        ql = '0;
        repeat (10) @(posedge mclk);
        #3 rst_b = 1'b1;
        repeat (5) @(posedge mclk);
        t_basic();
        t_mask();
        t_conc();
        t_refuse();
        t_modes();
        give_verdict();
    end

    // Watchdog: the tests need about 5 us
    initial begin
        #50000;
        fails++;
        give_verdict();
    end
endmodule : ddr_burst4_sram_interface_test
